// [src/irqx_ctrl.sv]
// Behaviour
// - Bits 7:6 set level of vector 803C
// - Bits 5:4 set level of vector 8038
// - Bits 3:2 set level of vector 8034
// - Bits 1:0 set level of vector 8030
// - Exception registers writable only when unlocked
// - Low exception register flag/enable bit layout
// - Clock stop sets flag when enabled
// - Stop enable starts RC oscillator, detector
// - Out-of-memory access sets address error flag
// - Word access to odd address sets flag
// - Undefined opcode execution sets its flag
// - Flags stay set until software writes zero
// - Flag and enable request vector 8080
// - High register mirrors UART0 request, enable
// - Mask control picks global enable gating
// - Nothing accepted without global interrupt enable, except UART0 request with mask control clear
// - Accept only levels above current level; UART0 request ignores current level
module irqx_ctrl
	import irqx_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        exception_write_unlock,
	input  wire logic        global_interrupt_enable,
	input  wire logic [2:0]  current_level,
	input  wire logic [3:0]  vec_req,
	input  wire logic        osc_halt_pin,
	input  wire logic        bad_address_evt,
	input  wire logic        odd_word_evt,
	input  wire logic        undefined_opcode_evt,
	input  wire logic        uart_zero_req,
	output logic             lowrc_run,
	output logic             int_take,
	output logic      [15:0] int_vector,
	output logic      [2:0]  int_level,
	output logic             irq
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	irqx_bus_t   bus_ff,    nxt_bus;
	irqx_aph_t   aph_ff,    nxt_aph;
	logic [31:0] rdata_ff,  nxt_rdata;
	logic [7:0]  lvl_ff,    nxt_lvl;
	logic [7:0]  excl_ff,   nxt_excl;
	logic [7:0]  exch_ff,   nxt_exch;
	irqx_evt_t   istat_ff,  nxt_istat;
	irqx_evt_t   imask_ff,  nxt_imask;
	logic        take_ff,   nxt_take;
	logic [15:0] vec_ff,    nxt_vec;
	logic [2:0]  ilvl_ff,   nxt_ilvl;
	logic        halt_s1_ff;
	logic        halt_s2_ff;
	logic        wr_en;
	logic        wr_lvl;
	logic        wr_excl;
	logic        wr_exch;
	logic        wr_istat;
	logic        wr_imask;
	logic [7:0]  wd;
	irqx_evt_t   evt;
	logic [7:0]  rmux;
	logic        aphase;
	wire logic [3:0] nxt_flag;
	wire logic [3:0] nxt_stat;

	// ---------------------------------------------------------------
	// Bus slave
	// ---------------------------------------------------------------
	// Reads take one wait state so that hrdata comes from a flop and
	// still reflects a write that completed in the previous cycle.
	assign aphase    = hsel & htrans[1] & hready;
	assign hreadyout = (bus_ff != BUS_RDW);
	assign hresp     = 1'b0;
	assign hrdata    = rdata_ff;
	assign wd        = hwdata[7:0];
	assign wr_en     = (bus_ff == BUS_WR);
	assign wr_lvl    = wr_en & (aph_ff.addr == A_LVL);
	assign wr_istat  = wr_en & (aph_ff.addr == A_ISTAT);
	assign wr_imask  = wr_en & (aph_ff.addr == A_IMASK);
	assign wr_excl   = wr_en & exception_write_unlock & (aph_ff.addr == A_EXCL);
	assign wr_exch   = wr_en & exception_write_unlock & (aph_ff.addr == A_EXCH);

	always_comb begin
		case (aph_ff.addr)
			A_LVL:   rmux = lvl_ff;
			A_EXCL:  rmux = excl_ff;
			A_EXCH:  rmux = exch_ff;
			A_ISTAT: rmux = {4'h0, istat_ff};
			A_IMASK: rmux = {4'h0, imask_ff};
			default: rmux = 8'h00;
		endcase
	end

	always_comb begin
		nxt_bus   = bus_ff;
		nxt_aph   = aph_ff;
		nxt_rdata = rdata_ff;
		case (bus_ff)
			BUS_RDW: begin
				nxt_rdata = {24'h000000, rmux};
				nxt_bus   = BUS_RD;
			end
			BUS_IDLE, BUS_WR, BUS_RD: begin
				if (aphase) begin
					nxt_aph.wr   = hwrite;
					nxt_aph.addr = {haddr[31:2], 2'b00};
					nxt_bus      = hwrite ? BUS_WR : BUS_RDW;
				end else begin
					nxt_bus = BUS_IDLE;
				end
			end
			default: nxt_bus = BUS_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_ff   <= BUS_IDLE;
			aph_ff   <= '0;
			rdata_ff <= 32'h00000000;
		end else begin
			bus_ff   <= nxt_bus;
			aph_ff   <= nxt_aph;
			rdata_ff <= nxt_rdata;
		end
	end

	// ---------------------------------------------------------------
	// Clock stop detector input synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			halt_s1_ff <= 1'b0;
			halt_s2_ff <= 1'b0;
		end else begin
			halt_s1_ff <= osc_halt_pin;
			halt_s2_ff <= halt_s1_ff;
		end
	end

	// ---------------------------------------------------------------
	// Exception and level registers
	// ---------------------------------------------------------------
	always_comb begin
		evt.osc_stop = halt_s2_ff & excl_ff[B_OSC_EN];
		evt.bad_addr = bad_address_evt;
		evt.odd_word = odd_word_evt;
		evt.undef_op = undefined_opcode_evt;
	end

	always_comb begin
		nxt_lvl   = lvl_ff;
		nxt_excl  = excl_ff;
		nxt_exch  = exch_ff;
		nxt_istat = istat_ff;
		nxt_imask = imask_ff;
		if (wr_lvl) begin
			nxt_lvl = wd;
		end
		if (wr_excl) begin
			nxt_excl[B_OSC_EN] = wd[B_OSC_EN];
			nxt_excl[B_BAD_EN] = wd[B_BAD_EN];
			nxt_excl[B_ODD_EN] = wd[B_ODD_EN];
			nxt_excl[B_UND_EN] = wd[B_UND_EN];
		end
		nxt_excl[B_OSC_FLG] = nxt_flag[3];
		nxt_excl[B_BAD_FLG] = nxt_flag[2];
		nxt_excl[B_ODD_FLG] = nxt_flag[1];
		nxt_excl[B_UND_FLG] = nxt_flag[0];
		// UART1 and relocation bits kept only as storage; reserved bit 1 held at zero
		if (wr_exch) begin
			nxt_exch[B_U1_FLG]  = wd[B_U1_FLG];
			nxt_exch[B_U1_EN]   = wd[B_U1_EN];
			nxt_exch[B_U0_EN]   = wd[B_U0_EN];
			nxt_exch[B_U1_MASK] = wd[B_U1_MASK];
			nxt_exch[B_U0_MASK] = wd[B_U0_MASK];
			nxt_exch[B_RELOC]   = wd[B_RELOC];
		end
		// read-only mirror of the UART request
		nxt_exch[B_U0_MIR] = uart_zero_req;
		nxt_exch[1]        = 1'b0;
		nxt_istat = nxt_stat;
		if (wr_imask) begin
			nxt_imask = wd[3:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lvl_ff   <= RST_LVL;
			excl_ff  <= RST_EXCL;
			exch_ff  <= RST_EXCH;
			istat_ff <= RST_EVT;
			imask_ff <= RST_EVT;
		end else begin
			lvl_ff   <= nxt_lvl;
			excl_ff  <= nxt_excl;
			exch_ff  <= nxt_exch;
			istat_ff <= nxt_istat;
			imask_ff <= nxt_imask;
		end
	end

	// ---------------------------------------------------------------
	// Sticky flag cells
	// ---------------------------------------------------------------
	// zero write clears, event wins
	irqx_flag_next #(.CLR_VAL(1'b0)) u_osc_flag (
		.cur  (excl_ff[B_OSC_FLG]),
		.hit  (evt.osc_stop),
		.wr   (wr_excl),
		.wbit (wd[B_OSC_FLG]),
		.nxt  (nxt_flag[3])
	);

	irqx_flag_next #(.CLR_VAL(1'b0)) u_bad_flag (
		.cur  (excl_ff[B_BAD_FLG]),
		.hit  (evt.bad_addr),
		.wr   (wr_excl),
		.wbit (wd[B_BAD_FLG]),
		.nxt  (nxt_flag[2])
	);

	irqx_flag_next #(.CLR_VAL(1'b0)) u_odd_flag (
		.cur  (excl_ff[B_ODD_FLG]),
		.hit  (evt.odd_word),
		.wr   (wr_excl),
		.wbit (wd[B_ODD_FLG]),
		.nxt  (nxt_flag[1])
	);

	irqx_flag_next #(.CLR_VAL(1'b0)) u_und_flag (
		.cur  (excl_ff[B_UND_FLG]),
		.hit  (evt.undef_op),
		.wr   (wr_excl),
		.wbit (wd[B_UND_FLG]),
		.nxt  (nxt_flag[0])
	);

	// Status bits clear on a written one
	irqx_flag_next #(.CLR_VAL(1'b1)) u_osc_stat (
		.cur  (istat_ff.osc_stop),
		.hit  (evt.osc_stop),
		.wr   (wr_istat),
		.wbit (wd[3]),
		.nxt  (nxt_stat[3])
	);

	irqx_flag_next #(.CLR_VAL(1'b1)) u_bad_stat (
		.cur  (istat_ff.bad_addr),
		.hit  (evt.bad_addr),
		.wr   (wr_istat),
		.wbit (wd[2]),
		.nxt  (nxt_stat[2])
	);

	irqx_flag_next #(.CLR_VAL(1'b1)) u_odd_stat (
		.cur  (istat_ff.odd_word),
		.hit  (evt.odd_word),
		.wr   (wr_istat),
		.wbit (wd[1]),
		.nxt  (nxt_stat[1])
	);

	irqx_flag_next #(.CLR_VAL(1'b1)) u_und_stat (
		.cur  (istat_ff.undef_op),
		.hit  (evt.undef_op),
		.wr   (wr_istat),
		.wbit (wd[0]),
		.nxt  (nxt_stat[0])
	);

	// enable runs RC oscillator and detector
	assign lowrc_run = excl_ff[B_OSC_EN];
	assign irq       = |(istat_ff & imask_ff);

	// ---------------------------------------------------------------
	// Request selection toward the core
	// ---------------------------------------------------------------
	always_comb begin
		logic [2:0] lv;
		logic       exc_req;
		logic       uart_ok;
		lv       = LVL_NONE;
		exc_req  = 1'b0;
		uart_ok  = 1'b0;
		nxt_take = 1'b0;
		nxt_vec  = 16'h0000;
		nxt_ilvl = LVL_NONE;
		for (int i = 0; i < 4; i++) begin
			lv = {1'b0, lvl_ff[2*i +: 2]};
			// enable and threshold; strict compare keeps lower vector
			if (vec_req[i] && (lv != LVL_NONE) && global_interrupt_enable &&
				(lv > current_level) && (lv > nxt_ilvl)) begin
				nxt_take = 1'b1;
				nxt_ilvl = lv;
				nxt_vec  = VEC_BASE + 16'(VEC_STEP * 16'(i));
			end
		end
		exc_req = (excl_ff[B_OSC_FLG] & excl_ff[B_OSC_EN]) |
			(excl_ff[B_BAD_FLG] & excl_ff[B_BAD_EN]) |
			(excl_ff[B_ODD_FLG] & excl_ff[B_ODD_EN]) |
			(excl_ff[B_UND_FLG] & excl_ff[B_UND_EN]);
		uart_ok = exch_ff[B_U0_MIR] & exch_ff[B_U0_EN] &
			(~exch_ff[B_U0_MASK] | global_interrupt_enable);
		if ((exc_req && global_interrupt_enable && (LVL_EXC > current_level)) || uart_ok) begin
			nxt_take = 1'b1;
			nxt_ilvl = LVL_EXC;
			nxt_vec  = VEC_EXC;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			take_ff <= 1'b0;
			vec_ff  <= 16'h0000;
			ilvl_ff <= LVL_NONE;
		end else begin
			take_ff <= nxt_take;
			vec_ff  <= nxt_vec;
			ilvl_ff <= nxt_ilvl;
		end
	end

	assign int_take   = take_ff;
	assign int_vector = vec_ff;
	assign int_level  = ilvl_ff;

endmodule : irqx_ctrl

// ---------------------------------------------------------------
// Sticky flag next-value cell
// ---------------------------------------------------------------
// An event beats a same-cycle clear, so a racing write never
// loses a fault; the flop itself stays in the parent.
module irqx_flag_next #(
	parameter logic CLR_VAL = 1'b0
) (
	input  wire logic cur,
	input  wire logic hit,
	input  wire logic wr,
	input  wire logic wbit,
	output logic      nxt
);

	logic cleared;

	always_comb begin
		cleared = cur;
		if (wr && (wbit == CLR_VAL)) begin
			cleared = 1'b0;
		end
		nxt = cleared | hit;
	end

endmodule : irqx_flag_next

// [src/irqx_pkg.sv]
package irqx_pkg;

	// ---------------------------------------------------------------
	// Register indices and bus byte addresses
	// ---------------------------------------------------------------
	localparam logic [15:0] IDX_LVL   = 16'h7f05;
	localparam logic [15:0] IDX_EXCL  = 16'h7f08;
	localparam logic [15:0] IDX_EXCH  = 16'h7f09;
	localparam logic [15:0] IDX_ISTAT = 16'h7f0e;
	localparam logic [15:0] IDX_IMASK = 16'h7f0f;
	localparam logic [31:0] A_LVL     = {14'h0000, IDX_LVL, 2'b00};
	localparam logic [31:0] A_EXCL    = {14'h0000, IDX_EXCL, 2'b00};
	localparam logic [31:0] A_EXCH    = {14'h0000, IDX_EXCH, 2'b00};
	localparam logic [31:0] A_ISTAT   = {14'h0000, IDX_ISTAT, 2'b00};
	localparam logic [31:0] A_IMASK   = {14'h0000, IDX_IMASK, 2'b00};

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int B_OSC_FLG  = 7;
	localparam int B_OSC_EN   = 6;
	localparam int B_BAD_FLG  = 5;
	localparam int B_BAD_EN   = 4;
	localparam int B_ODD_FLG  = 3;
	localparam int B_ODD_EN   = 2;
	localparam int B_UND_FLG  = 1;
	localparam int B_UND_EN   = 0;
	localparam int B_U1_FLG   = 7;
	localparam int B_U1_EN    = 6;
	localparam int B_U0_MIR   = 5;
	localparam int B_U0_EN    = 4;
	localparam int B_U1_MASK  = 3;
	localparam int B_U0_MASK  = 2;
	localparam int B_RELOC    = 0;

	// ---------------------------------------------------------------
	// Reset values, vectors, levels
	// ---------------------------------------------------------------
	localparam logic [7:0]  RST_LVL   = 8'h00;
	localparam logic [7:0]  RST_EXCL  = 8'h00;
	localparam logic [7:0]  RST_EXCH  = 8'h00;
	localparam logic [3:0]  RST_EVT   = 4'h0;
	localparam logic [15:0] VEC_BASE  = 16'h8030;
	localparam logic [15:0] VEC_STEP  = 16'h0004;
	localparam logic [15:0] VEC_EXC   = 16'h8080;
	localparam logic [2:0]  LVL_EXC   = 3'h4;
	localparam logic [2:0]  LVL_NONE  = 3'h0;

	typedef struct packed {
		logic osc_stop;
		logic bad_addr;
		logic odd_word;
		logic undef_op;
	} irqx_evt_t;

	typedef struct packed {
		logic        wr;
		logic [31:0] addr;
	} irqx_aph_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WR   = 2'b01,
		BUS_RDW  = 2'b11,
		BUS_RD   = 2'b10
	} irqx_bus_t;

endpackage : irqx_pkg

// [verification/irqx_core_model.sv]
// ---------------------------------------------------------------
// Core status word and fault detector model
// ---------------------------------------------------------------
module irqx_core_model
	import irqx_pkg::*;
(
	input  wire logic [15:0] processor_status_word,
	input  wire irqx_evt_t   fault,
	output logic             unlock,
	output logic             gie,
	output logic      [2:0]  cur_lvl,
	output irqx_evt_t        evt
);
	timeunit 1ns;
	timeprecision 1ps;
	assign unlock  = processor_status_word[11];
	assign gie     = processor_status_word[7];
	assign cur_lvl = processor_status_word[10:8];
	assign evt     = fault;
endmodule : irqx_core_model

// [verification/irqx_ctrl_props.sv]
// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module irqx_ctrl_props
	import irqx_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        exception_write_unlock,
	input wire logic        global_interrupt_enable,
	input wire logic [2:0]  current_level,
	input wire logic [3:0]  vec_req,
	input wire logic        lowrc_run,
	input wire logic        int_take,
	input wire logic [15:0] int_vector,
	input wire logic [2:0]  int_level,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Programmable vector presented, not the exception one
	logic prog;
	assign prog = int_take && int_vector != VEC_EXC;
	property p_exc; int_take && int_level == LVL_EXC |-> int_vector == VEC_EXC; endproperty
	a_exc: assert property (p_exc) else $error("exception level at wrong vector");
	property p_none; !int_take |-> int_vector == 16'h0000 && int_level == LVL_NONE; endproperty
	a_none: assert property (p_none) else $error("vector shown while idle");
	property p_gie; prog |-> $past(global_interrupt_enable); endproperty
	a_gie: assert property (p_gie) else $error("request taken with interrupts off");
	property p_lvl; prog |-> int_level > $past(current_level) && int_level != LVL_EXC; endproperty
	a_lvl: assert property (p_lvl) else $error("level not above current");
	property p_vec; prog |-> int_vector[15:4] == 12'h803 && ($past(vec_req) & (4'h1 << int_vector[3:2])) != 4'h0; endproperty
	a_vec: assert property (p_vec) else $error("vector without request");
	property p_lowrc; $rose(lowrc_run) |-> $past(exception_write_unlock); endproperty
	a_lowrc: assert property (p_lowrc) else $error("detector started while locked");
	property p_irq; $fell(irq) |-> $past(hsel && htrans[1] && hwrite && hready, 2); endproperty
	a_irq: assert property (p_irq) else $error("interrupt dropped without a write");
	property p_rd; hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
	a_rd: assert property (p_rd) else $error("read wait state wrong");
	c_exc: cover property (int_take && int_vector == VEC_EXC);
	c_prog: cover property (prog);
	c_irq: cover property ($fell(irq));
endmodule : irqx_ctrl_props
bind irqx_ctrl irqx_ctrl_props u_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
	.exception_write_unlock, .global_interrupt_enable, .current_level, .vec_req, .lowrc_run, .int_take,
	.int_vector, .int_level, .irq);

// [verification/irqx_ctrl_tb_top.sv]
module irqx_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import irqx_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, hresp, uart_req, unlock, gie, lowrc, take, irq;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans;
	logic [2:0]  hsize, cur_lvl, lvl;
	logic [15:0] processor_status_word, vec;
	logic [3:0]  vec_req;
	irqx_evt_t   fault, evt;
	int          failures, n_checks, cyc;
	localparam logic [5:0][31:0] RST_ADDR = {32'h100, A_IMASK, A_ISTAT, A_EXCH, A_EXCL, A_LVL};
	irqx_core_model core (.processor_status_word(processor_status_word), .fault(fault), .unlock(unlock), .gie(gie), .cur_lvl(cur_lvl), .evt(evt));
	irqx_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .exception_write_unlock(unlock), .global_interrupt_enable(gie),
		.current_level(cur_lvl), .vec_req(vec_req), .osc_halt_pin(evt.osc_stop),
		.bad_address_evt(evt.bad_addr), .odd_word_evt(evt.odd_word), .undefined_opcode_evt(evt.undef_op),
		.uart_zero_req(uart_req), .lowrc_run(lowrc), .int_take(take), .int_vector(vec), .int_level(lvl),
		.irq(irq));
	// ---------------------------------------------------------------
	// Bus master and compare tasks
	// ---------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Single word transfer, waits on hready in both phases
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr  <= a;
		do @(posedge hclk); while (!hready);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (!hready);
		r = hrdata;
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("rdata", e, r);
		chk("hresp", 32'h0, 32'(hresp));
	endtask : rd
	task automatic ck_int(input logic t, input logic [15:0] v, input logic [2:0] l);
		chk("take", 32'(t), 32'(take));
		chk("vector", 32'(v), 32'(vec));
		chk("level", 32'(l), 32'(lvl));
	endtask : ck_int
	task automatic pk(input logic [15:0] p, input logic t, input logic [15:0] v, input logic [2:0] l);
		processor_status_word <= p;
		repeat (2) @(posedge hclk);
		ck_int(t, v, l);
	endtask : pk
	task automatic pulse(input irqx_evt_t e, input int n);
		fault <= e;
		repeat (n) @(posedge hclk);
		fault <= 4'h0;
		@(posedge hclk);
	endtask : pulse
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// Ceiling well above the fewer than two hundred cycles the tests need
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			tally_and_finish;
		end
	end
	initial begin
		{hresetn, hsel, hwrite, uart_req, haddr, hwdata, htrans, processor_status_word, vec_req, fault} = '0;
		hsize = 3'h2;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 6; i++) rd(RST_ADDR[i], 32'h0);
		$display("test reset done");
		processor_status_word <= 16'h0080;
		for (int i = 0; i < 4; i++) begin
			for (int c = 0; c < 4; c++) begin
				wr(A_LVL, 32'(c << (2 * i)));
				vec_req <= 4'(1 << i);
				repeat (2) @(posedge hclk);
				ck_int(c != 0, c != 0 ? 16'(VEC_BASE + VEC_STEP * i) : 16'h0, 3'(c));
			end
		end
		vec_req <= 4'hf;
		wr(A_LVL, 32'h6c);
		pk(16'h0080, 1'b1, 16'h8034, 3'h3);
		pk(16'h0380, 1'b0, 16'h0, 3'h0);
		pk(16'h0280, 1'b1, 16'h8034, 3'h3);
		pk(16'h0000, 1'b0, 16'h0, 3'h0);
		wr(A_LVL, 32'hff);
		pk(16'h0080, 1'b1, 16'h8030, 3'h3);
		$display("test levels done");
		vec_req <= 4'h0;
		processor_status_word <= 16'h0000;
		wr(A_EXCL, 32'h55);
		rd(A_EXCL, 32'h0);
		chk("lowrc", 32'h0, 32'(lowrc));
		processor_status_word <= 16'h0880;
		wr(A_EXCL, 32'h55);
		rd(A_EXCL, 32'h55);
		chk("lowrc", 32'h1, 32'(lowrc));
		pulse(4'b0100, 1);
		rd(A_EXCL, 32'h75);
		ck_int(1'b1, VEC_EXC, LVL_EXC);
		pk(16'h0800, 1'b0, 16'h0, 3'h0);
		pk(16'h0c80, 1'b0, 16'h0, 3'h0);
		pk(16'h0880, 1'b1, VEC_EXC, LVL_EXC);
		pulse(4'b0011, 1);
		rd(A_EXCL, 32'h7f);
		pulse(4'b1000, 4);
		rd(A_EXCL, 32'hff);
		wr(A_EXCL, 32'hd5);
		rd(A_EXCL, 32'hd5);
		wr(A_EXCL, 32'h55);
		rd(A_EXCL, 32'h55);
		ck_int(1'b0, 16'h0, 3'h0);
		$display("test exceptions done");
		rd(A_ISTAT, 32'hf);
		wr(A_IMASK, 32'h2);
		@(posedge hclk);
		chk("irq", 32'h1, 32'(irq));
		wr(A_ISTAT, 32'h2);
		@(posedge hclk);
		chk("irq", 32'h0, 32'(irq));
		rd(A_ISTAT, 32'hd);
		$display("test irq done");
		processor_status_word <= 16'h0800;
		uart_req <= 1'b1;
		wr(A_EXCH, 32'h10);
		rd(A_EXCH, 32'h30);
		ck_int(1'b1, VEC_EXC, LVL_EXC);
		wr(A_EXCH, 32'h14);
		rd(A_EXCH, 32'h34);
		ck_int(1'b0, 16'h0, 3'h0);
		pk(16'h0880, 1'b1, VEC_EXC, LVL_EXC);
		$display("test uart done");
		tally_and_finish;
	end
endmodule : irqx_ctrl_tb_top
